/* File: core/ebl_pkg.sv */
// shared constants and carrier types for the external bus latch block
// assumes the oscillator clock drives sys_clk; one machine cycle is six of it
package ebl_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_SYS_CTRL = 8'hB1;
   localparam logic [7:0] OFS_PTR_SEL  = 8'h92;
   localparam logic [7:0] OFS_PTR_LOW  = 8'h82;
   localparam logic [7:0] OFS_PTR_HIGH = 8'h83;
   localparam logic [7:0] OFS_MOVE_CMD = 8'hC0;
   localparam logic [7:0] OFS_MOVE_WR  = 8'hC1;
   localparam logic [7:0] OFS_MOVE_RD  = 8'hC2;
   localparam logic [7:0] OFS_STATUS   = 8'hC3;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int         SYS_ALE_EN_BIT = 5;
   localparam int         CMD_INC_BIT    = 0;
   localparam int         CMD_READ_BIT   = 1;
   localparam int         CMD_WRITE_BIT  = 2;
   localparam int         SEL_WIDTH      = 3;
   localparam int         PTR_COUNT      = 8;
   localparam logic [7:0] SYS_CTRL_RST   = 8'hA1;
   localparam logic [2:0] PTR_SEL_RST    = 3'h0;
   localparam logic [15:0] PTR_RST       = 16'h0000;

   // ----------------------------------------------------------------
   // timing, in oscillator periods (sys_clk is the oscillator)
   // ----------------------------------------------------------------
   localparam int         FETCH_PERIODS  = 3;
   localparam int         DATA_PERIODS   = 6;
   localparam int         OSC_PER_CLK    = 1;
   localparam logic [2:0] PH_LAST        = 3'(2 * FETCH_PERIODS / OSC_PER_CLK - 1);
   localparam logic [2:0] PH_ALE_A       = 3'h0;
   localparam logic [2:0] PH_ALE_B       = 3'(FETCH_PERIODS / OSC_PER_CLK);
   localparam logic [2:0] DATA_STB_CYC   = 3'(DATA_PERIODS / OSC_PER_CLK - 2);

   // ----------------------------------------------------------------
   // pin bundle
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        ale;
      logic        fetch_n;
      logic        read_n;
      logic        write_n;
      logic [7:0]  p0_out;
      logic        p0_oe_n;
      logic [7:0]  p2_out;
   } ebl_pins_t;

   typedef enum logic [1:0] {MV_IDLE, MV_WAIT, MV_ADDR, MV_STROBE} ebl_move_t;

endpackage

/* File: core/ebl_pin_sync.sv */
// three-stage synchroniser for a level arriving from a pin
// assumes the input may change at any time relative to sys_clk
`timescale 1ns/1ps
module ebl_pin_sync (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // level in and out
   input  wire logic pin_in,
   output logic      level_ff
);
   logic s1_ff, s2_ff, s3_ff;

   // ----------------------------------------------------------------
   // shift chain; s1 feeds only s2
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_ff <= 1'b1;
         s2_ff <= 1'b1;
         s3_ff <= 1'b1;
      end else begin
         s1_ff <= pin_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // change accepted once second and third stage agree
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         level_ff <= 1'b1;
      end else if (s2_ff == s3_ff) begin
         level_ff <= s3_ff;
      end
   end
endmodule

/* File: core/ebl_ptr_mem.sv */
// bank of eight 16-bit data pointers with one registered read port
// assumes the owner supplies the index it wants to see next cycle
`timescale 1ns/1ps
module ebl_ptr_mem
   import ebl_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // write port
   input  wire logic        wr_en,
   input  wire logic [2:0]  wr_idx,
   input  wire logic [15:0] wr_data,
   // read port
   input  wire logic [2:0]  rd_idx,
   output logic [15:0]      rd_q_ff
);
   logic [15:0] mem_ff [PTR_COUNT];

   // ----------------------------------------------------------------
   // storage, one entry per pointer
   // ----------------------------------------------------------------
   for (genvar i = 0; i < PTR_COUNT; i++) begin : g_ent
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            mem_ff[i] <= PTR_RST;
         end else if (wr_en && wr_idx == 3'(i)) begin
            mem_ff[i] <= wr_data;
         end
      end
   end

   // read with write forwarding so the port is never a cycle stale
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_q_ff <= PTR_RST;
      end else if (wr_en && wr_idx == rd_idx) begin
         rd_q_ff <= wr_data;
      end else begin
         rd_q_ff <= mem_ff[rd_idx];
      end
   end
endmodule

/* File: core/ebl_top.sv */
// external bus strobe generator with address-latch pulse and pointer bank
// assumes sys_clk is the oscillator and the register port is synchronous
//
// Functional notes
// - low address valid on port at latch fall
// - latch strobe pulses twice per machine cycle
// - no latch pulse while data strobes active
// - without data moves latch runs at third rate
// - latch enable bit resets one, writable
// - external access low forces latch enabled
// - eight 16-bit pointers, one active
// - three-bit select field picks active pointer
// - pointer operations act on selected entry only
// - active pointer seen as high and low bytes
// - port carries address then data, multiplexed
// - fetch cycle spans three oscillator periods
// - data cycle spans six oscillator periods
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module ebl_top
   import ebl_pkg::*;
(
   // clock and reset
   input  wire logic            sys_clk,
   input  wire logic            rst_n,
   // register port
   input  wire logic [7:0]      reg_addr,
   input  wire logic [7:0]      reg_wdata,
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   output logic [7:0]           reg_rdata_ff,
   // fetch source from the core
   input  wire logic            fetch_req,
   input  wire logic [15:0]     fetch_addr,
   // device pins
   input  wire logic            external_access_pin_n,
   input  wire logic [7:0]      mux_addr_data_port_in,
   output ebl_pkg::ebl_pins_t   pins_ff
);
   import ebl_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [2:0]  phase_ff;
   logic [2:0]  nxt_phase;
   logic [7:0]  sys_ctrl_ff;
   logic [2:0]  ptr_sel_ff;
   logic [2:0]  nxt_ptr_sel;
   logic [7:0]  move_wr_ff;
   logic [7:0]  move_rd_ff;
   logic        move_is_wr_ff;
   logic        move_done_ff;
   ebl_move_t   move_ff;
   logic [2:0]  stb_cnt_ff;
   logic        ea_lvl;
   logic        ale_on;
   logic        fetch_on;
   logic [15:0] ptr_q;
   logic        ptr_we;
   logic [15:0] ptr_wdata;
   logic        wr_hit;
   logic        cmd_wr;
   logic        ale_slot;
   logic        data_slot;
   logic [15:0] fetch_lat_ff;
   ebl_pins_t   nxt_pins;

   assign wr_hit = reg_wr;
   assign cmd_wr = wr_hit && reg_addr == OFS_MOVE_CMD;

   // ----------------------------------------------------------------
   // external access pin crossing
   // ----------------------------------------------------------------
   ebl_pin_sync u_ea_sync (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .pin_in   (external_access_pin_n),
      .level_ff (ea_lvl)
   );

   // ----------------------------------------------------------------
   // machine cycle phase counter, six oscillator periods
   // ----------------------------------------------------------------
   assign nxt_phase = (phase_ff == PH_LAST) ? 3'h0 : phase_ff + 3'h1;

   // free running so the latch slots recur every machine cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_ff <= PH_LAST;
      end else begin
         phase_ff <= nxt_phase;
      end
   end

   // ----------------------------------------------------------------
   // system control register
   // ----------------------------------------------------------------
   // all bits stored; only the latch enable steers logic here
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sys_ctrl_ff <= SYS_CTRL_RST;
      end else if (wr_hit && reg_addr == OFS_SYS_CTRL) begin
         sys_ctrl_ff <= reg_wdata;
      end
   end

   // pin low overrides a cleared enable bit
   assign ale_on = sys_ctrl_ff[SYS_ALE_EN_BIT] || !ea_lvl;

   // ----------------------------------------------------------------
   // pointer select register
   // ----------------------------------------------------------------
   always_comb begin
      nxt_ptr_sel = ptr_sel_ff;
      if (wr_hit && reg_addr == OFS_PTR_SEL) begin
         nxt_ptr_sel = reg_wdata[SEL_WIDTH-1:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr_sel_ff <= PTR_SEL_RST;
      end else begin
         ptr_sel_ff <= nxt_ptr_sel;
      end
   end

   // ----------------------------------------------------------------
   // pointer bank and byte access
   // ----------------------------------------------------------------
   // reads the entry the select will hold next, so ptr_q is current
   ebl_ptr_mem u_ptr (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .wr_en   (ptr_we),
      .wr_idx  (ptr_sel_ff),
      .wr_data (ptr_wdata),
      .rd_idx  (nxt_ptr_sel),
      .rd_q_ff (ptr_q)
   );

   // byte writes and increment only touch the selected entry
   always_comb begin
      ptr_we    = 1'b0;
      ptr_wdata = ptr_q;
      if (wr_hit && reg_addr == OFS_PTR_LOW) begin
         ptr_we    = 1'b1;
         ptr_wdata = {ptr_q[15:8], reg_wdata};
      end else if (wr_hit && reg_addr == OFS_PTR_HIGH) begin
         ptr_we    = 1'b1;
         ptr_wdata = {reg_wdata, ptr_q[7:0]};
      end else if (cmd_wr && reg_wdata[CMD_INC_BIT]) begin
         ptr_we    = 1'b1;
         ptr_wdata = ptr_q + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // external data move sequencer
   // ----------------------------------------------------------------
   // the move waits for the second latch slot, then runs its strobe
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         move_ff    <= MV_IDLE;
         stb_cnt_ff <= 3'h0;
      end else begin
         unique case (move_ff)
            MV_IDLE: begin
               if (cmd_wr && (reg_wdata[CMD_READ_BIT] ||
                              reg_wdata[CMD_WRITE_BIT])) begin
                  move_ff <= MV_WAIT;
               end
            end
            MV_WAIT: begin
               if (nxt_phase == PH_ALE_B) begin
                  move_ff <= MV_ADDR;
               end
            end
            MV_ADDR: begin
               move_ff    <= MV_STROBE;
               stb_cnt_ff <= DATA_STB_CYC;
            end
            // strobe low while the count runs 4..1, released at 0
            MV_STROBE: begin
               if (stb_cnt_ff == 3'h0) begin
                  move_ff <= MV_IDLE;
               end else begin
                  stb_cnt_ff <= stb_cnt_ff - 3'h1;
               end
            end
         endcase
      end
   end

   // direction, write byte and done flag
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         move_is_wr_ff <= 1'b0;
         move_wr_ff    <= 8'h00;
         move_done_ff  <= 1'b0;
      end else begin
         if (wr_hit && reg_addr == OFS_MOVE_WR) begin
            move_wr_ff <= reg_wdata;
         end
         if (move_ff == MV_IDLE && cmd_wr) begin
            move_is_wr_ff <= reg_wdata[CMD_WRITE_BIT];
         end
         // finishing wins over a clear in the same cycle
         if (move_ff == MV_STROBE && stb_cnt_ff == 3'h0) begin
            move_done_ff <= 1'b1;
         end else if (cmd_wr) begin
            move_done_ff <= 1'b0;
         end
      end
   end

   // byte sampled in the last strobe cycle, before release
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         move_rd_ff <= 8'h00;
      end else if (move_ff == MV_STROBE && stb_cnt_ff == 3'h0 &&
                   !move_is_wr_ff) begin
         move_rd_ff <= mux_addr_data_port_in;
      end
   end

   // ----------------------------------------------------------------
   // pin generation
   // ----------------------------------------------------------------
   assign ale_slot  = nxt_phase == PH_ALE_A || nxt_phase == PH_ALE_B;
   assign data_slot = move_ff == MV_ADDR || move_ff == MV_STROBE;
   // fetches yield their slots to a pending or running move
   assign fetch_on  = fetch_req && move_ff == MV_IDLE;

   // fetch address held for the whole three-period fetch
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         fetch_lat_ff <= 16'h0000;
      end else if (ale_slot) begin
         fetch_lat_ff <= fetch_addr;
      end
   end

   // next pin state from the phase that is about to start
   always_comb begin
      nxt_pins         = '0;
      nxt_pins.fetch_n = 1'b1;
      nxt_pins.read_n  = 1'b1;
      nxt_pins.write_n = 1'b1;
      nxt_pins.p0_oe_n = 1'b1;
      nxt_pins.p2_out  = pins_ff.p2_out;
      if (move_ff == MV_WAIT && nxt_phase == PH_ALE_B) begin
         // latch pulse for the move, pointer address on both ports
         nxt_pins.ale     = ale_on;
         nxt_pins.p0_out  = ptr_q[7:0];
         nxt_pins.p0_oe_n = 1'b0;
         nxt_pins.p2_out  = ptr_q[15:8];
      end else if (move_ff == MV_ADDR) begin
         // address held past the falling latch edge
         nxt_pins.p0_out  = pins_ff.p0_out;
         nxt_pins.p0_oe_n = 1'b0;
      end else if (move_ff == MV_STROBE) begin
         // data strobe active: latch pulse suppressed
         nxt_pins.ale     = 1'b0;
         nxt_pins.read_n  = move_is_wr_ff;
         nxt_pins.write_n = !move_is_wr_ff;
         nxt_pins.p0_out  = move_is_wr_ff ? move_wr_ff : 8'h00;
         nxt_pins.p0_oe_n = !move_is_wr_ff;
         if (stb_cnt_ff == 3'h0) begin
            // strobes released; the phase-3 slot pulses again
            nxt_pins.ale     = ale_on;
            nxt_pins.read_n  = 1'b1;
            nxt_pins.write_n = 1'b1;
            nxt_pins.p0_oe_n = 1'b1;
         end
      end else if (ale_slot) begin
         nxt_pins.ale     = ale_on;
         nxt_pins.p0_out  = fetch_addr[7:0];
         nxt_pins.p0_oe_n = !fetch_on;
         nxt_pins.p2_out  = fetch_on ? fetch_addr[15:8] : pins_ff.p2_out;
      end else if (phase_ff == PH_ALE_A || phase_ff == PH_ALE_B) begin
         // hold phase: address still driven, latch low
         nxt_pins.p0_out  = fetch_lat_ff[7:0];
         // keep driving what the pulse put out, even if the core lets go
         nxt_pins.p0_oe_n = pins_ff.p0_oe_n;
      end else if (fetch_on && !pins_ff.p0_oe_n) begin
         // third period of the fetch: strobe low, port released
         nxt_pins.fetch_n = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pins_ff         <= '0;
         pins_ff.fetch_n <= 1'b1;
         pins_ff.read_n  <= 1'b1;
         pins_ff.write_n <= 1'b1;
         pins_ff.p0_oe_n <= 1'b1;
      end else begin
         pins_ff <= nxt_pins;
      end
   end

   // ----------------------------------------------------------------
   // register read port, data one cycle after the strobe
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_ff <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            OFS_SYS_CTRL: reg_rdata_ff <= sys_ctrl_ff;
            OFS_PTR_SEL:  reg_rdata_ff <= {5'h00, ptr_sel_ff};
            OFS_PTR_LOW:  reg_rdata_ff <= ptr_q[7:0];
            OFS_PTR_HIGH: reg_rdata_ff <= ptr_q[15:8];
            OFS_MOVE_WR:  reg_rdata_ff <= move_wr_ff;
            OFS_MOVE_RD:  reg_rdata_ff <= move_rd_ff;
            OFS_STATUS:   reg_rdata_ff <= {5'h00, ea_lvl, move_done_ff,
                                           move_ff != MV_IDLE};
            default:      reg_rdata_ff <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_ale_pair;
      @(posedge sys_clk) disable iff (!rst_n)
      (pins_ff.ale && data_slot == 1'b0 && move_ff == MV_IDLE) |->
         ##3 (pins_ff.ale || !ale_on || move_ff != MV_IDLE);
   endproperty
   a_ale_pair: assert property (p_ale_pair)
      else $error("latch pulses not three periods apart");

   property p_ale_rate;
      @(posedge sys_clk) disable iff (!rst_n)
      (move_ff == MV_IDLE && ale_on && pins_ff.ale) |->
         ##1 !pins_ff.ale ##1 !pins_ff.ale;
   endproperty
   a_ale_rate: assert property (p_ale_rate)
      else $error("latch pulse longer than one period");

   property p_no_ale_in_strobe;
      @(posedge sys_clk) disable iff (!rst_n)
      (!pins_ff.read_n || !pins_ff.write_n) |-> !pins_ff.ale;
   endproperty
   a_no_ale_in_strobe: assert property (p_no_ale_in_strobe)
      else $error("latch pulse during data strobe");

   property p_ea_forces;
      @(posedge sys_clk) disable iff (!rst_n)
      (!ea_lvl && move_ff == MV_IDLE && ale_slot) |=> pins_ff.ale;
   endproperty
   a_ea_forces: assert property (p_ea_forces)
      else $error("latch disabled while external access low");

   property p_addr_at_fall;
      @(posedge sys_clk) disable iff (!rst_n)
      (pins_ff.ale && !pins_ff.p0_oe_n) |=> !pins_ff.p0_oe_n &&
                      pins_ff.p0_out == $past(pins_ff.p0_out);
   endproperty
   a_addr_at_fall: assert property (p_addr_at_fall)
      else $error("low address not held at latch fall");

   property p_fetch_len;
      @(posedge sys_clk) disable iff (!rst_n)
      $fell(pins_ff.fetch_n) |->
         $past(pins_ff.ale, 2) ##1 pins_ff.fetch_n;
   endproperty
   a_fetch_len: assert property (p_fetch_len)
      else $error("fetch cycle not three periods");

   property p_data_len;
      @(posedge sys_clk) disable iff (!rst_n)
      (move_ff == MV_ADDR) |->
         ##2 (!pins_ff.read_n || !pins_ff.write_n) [*4]
         ##1 (pins_ff.read_n && pins_ff.write_n);
   endproperty
   a_data_len: assert property (p_data_len)
      else $error("data cycle not six periods");

   property p_sel_write;
      @(posedge sys_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == OFS_PTR_SEL) |=>
         ptr_sel_ff == $past(reg_wdata[2:0]);
   endproperty
   a_sel_write: assert property (p_sel_write)
      else $error("pointer select not updated");

   property p_inc_sel;
      @(posedge sys_clk) disable iff (!rst_n)
      (cmd_wr && reg_wdata[CMD_INC_BIT] && !reg_rd) |=>
         ptr_q == $past(ptr_q) + 16'h0001;
   endproperty
   a_inc_sel: assert property (p_inc_sel)
      else $error("increment missed selected pointer");

   property p_ctrl_write;
      @(posedge sys_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == OFS_SYS_CTRL) |=>
         sys_ctrl_ff[SYS_ALE_EN_BIT] == $past(reg_wdata[5]);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write)
      else $error("latch enable bit not writable");

endmodule

/* File: sim/ebl_ext_mem.sv */
// external memory and low-address latch on the bus pins
// assumes the pins come straight from the block; port wire resolved here
`timescale 1ns/1ps
module ebl_ext_mem
   import ebl_pkg::*;
(
   // clock and pins
   input  wire logic               sys_clk,
   input  wire ebl_pkg::ebl_pins_t pins,
   // resolved port and captures
   output logic [7:0]              port,
   output logic [15:0]             acc_q,
   output logic [7:0]              wr_q
);
   logic [15:0] lat_q;
   logic [7:0]  last_ff = 8'h00;
   logic        rd_on;
   // merged read strobe, high when either strobe is low
   assign rd_on = !(pins.fetch_n & pins.read_n);
   // answers at once, so even the short fetch cycle is met
   assign port = !pins.p0_oe_n ? pins.p0_out
               : rd_on ? (lat_q[7:0] ^ lat_q[15:8] ^ 8'h5A)
               : ~last_ff;
   // released port shows a moving pattern, never a held value
   always @(posedge sys_clk) last_ff <= port;
   // latch closes on the falling strobe; idle pulses capture junk too
   always @(negedge pins.ale) lat_q <= {pins.p2_out, port};
   // address and write byte kept per access, mid-cycle
   always @(negedge sys_clk) begin
      if (rd_on | !pins.write_n) acc_q <= lat_q;
      if (!pins.write_n) wr_q <= port;
   end
endmodule

/* File: sim/ebl_top_bench.sv */
// self-checking bench for the latch strobe and pointer bank
// assumes the memory model resolves the port wire
`timescale 1ns/1ps
module ebl_top_bench;
   import ebl_pkg::*;
   logic        sys_clk, rst_n, reg_wr, reg_rd, fetch_req, ea_n;
   logic [7:0]  reg_addr, reg_wdata, rdata, port, wr_q;
   logic [15:0] fetch_addr, acc_q;
   ebl_pins_t   pins;
   int          n_errors, checked, cyc, na, ns, nf, nc;
   ebl_top u_ebl_top (.sys_clk(sys_clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata_ff(rdata), .fetch_req(fetch_req),
      .fetch_addr(fetch_addr), .external_access_pin_n(ea_n),
      .mux_addr_data_port_in(port), .pins_ff(pins));
   ebl_ext_mem u_ebl_ext_mem (.sys_clk(sys_clk), .pins(pins),
      .port(port), .acc_q(acc_q), .wr_q(wr_q));
   // 8 ns clock
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   // hang guard, well above the few hundred cycles needed
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_errors++;
         report_and_stop;
      end
   end
   task report_and_stop;
      if (n_errors == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one-cycle strobes; a gap cycle between calls
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      #1;
   endtask
   // counts strobe cycles over n settled samples
   task watch(input int n);
      logic s;
      na = 0;
      ns = 0;
      nf = 0;
      nc = 0;
      repeat (n) begin
         @(posedge sys_clk);
         #1;
         s = (pins.read_n === 1'b0) || (pins.write_n === 1'b0);
         na += (pins.ale === 1'b1);
         ns += s;
         nf += (pins.fetch_n === 1'b0);
         nc += (s && pins.ale === 1'b1);
      end
   endtask
   // ----
   // scenarios
   // ----
   task t_reset;
      rd(OFS_SYS_CTRL);
      chk(rdata, SYS_CTRL_RST);
      rd(OFS_PTR_SEL);
      chk(rdata, {5'h00, PTR_SEL_RST});
      rd(8'h10);
      chk(rdata, 8'h00);
   endtask
   task t_idle;
      watch(30);
      chk(na, 10);
      chk(nf, 0);
   endtask
   task t_ale_off;
      wr(OFS_SYS_CTRL, 8'h81);
      watch(12);
      chk(na, 4);
      @(posedge sys_clk) ea_n <= 1'b1;
      watch(9);
      watch(12);
      chk(na, 0);
      rd(OFS_SYS_CTRL);
      chk(rdata, 8'h81);
      wr(OFS_SYS_CTRL, 8'hA1);
      @(posedge sys_clk) ea_n <= 1'b0;
      watch(9);
   endtask
   task t_ptrs;
      for (int i = 0; i < 8; i++) begin
         wr(OFS_PTR_SEL, 8'(i));
         wr(OFS_PTR_LOW, 8'(i * 17));
         wr(OFS_PTR_HIGH, 8'(8'hA0 + i));
      end
      for (int i = 0; i < 8; i++) begin
         wr(OFS_PTR_SEL, 8'(i));
         rd(OFS_PTR_SEL);
         chk(rdata, 8'(i));
         rd(OFS_PTR_LOW);
         chk(rdata, 8'(i * 17));
         rd(OFS_PTR_HIGH);
         chk(rdata, 8'(8'hA0 + i));
      end
   endtask
   // upper select bits ignored; carry reaches the high byte only here
   task t_inc;
      wr(OFS_PTR_SEL, 8'hFB);
      rd(OFS_PTR_SEL);
      chk(rdata, 8'h03);
      wr(OFS_PTR_LOW, 8'hFF);
      wr(OFS_MOVE_CMD, 8'h01);
      rd(OFS_PTR_LOW);
      chk(rdata, 8'h00);
      rd(OFS_PTR_HIGH);
      chk(rdata, 8'hA4);
      wr(OFS_PTR_SEL, 8'h04);
      rd(OFS_PTR_LOW);
      chk(rdata, 8'h44);
   endtask
   task t_move_wr;
      wr(OFS_PTR_SEL, 8'h05);
      wr(OFS_PTR_LOW, 8'h7A);
      wr(OFS_PTR_HIGH, 8'h3C);
      wr(OFS_MOVE_WR, 8'h96);
      wr(OFS_MOVE_CMD, 8'h04);
      watch(24);
      chk(na, 7);
      chk(nc, 0);
      chk(ns, 4);
      chk(acc_q, 16'h3C7A);
      chk(wr_q, 8'h96);
      // status: done set, not busy, external access pin low
      rd(OFS_STATUS);
      chk(rdata, 8'h02);
   endtask
   task t_move_rd;
      wr(OFS_MOVE_CMD, 8'h02);
      watch(24);
      chk(ns, 4);
      chk(nc, 0);
      chk(acc_q, 16'h3C7A);
      rd(OFS_MOVE_RD);
      chk(rdata, 8'h7A ^ 8'h3C ^ 8'h5A);
   endtask
   task t_fetch;
      @(posedge sys_clk);
      fetch_addr <= 16'h5E21;
      fetch_req  <= 1'b1;
      watch(6);
      watch(12);
      chk(nf, 4);
      chk(na, 4);
      chk(acc_q, 16'h5E21);
      @(posedge sys_clk) fetch_req <= 1'b0;
   endtask
   // main sequence
   initial begin
      rst_n      = 1'b0;
      reg_wr     = 1'b0;
      reg_rd     = 1'b0;
      reg_addr   = 8'h00;
      reg_wdata  = 8'h00;
      fetch_req  = 1'b0;
      fetch_addr = 16'h0000;
      ea_n       = 1'b0;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      watch(6);
      t_reset;
      t_idle;
      t_ale_off;
      t_ptrs;
      t_inc;
      t_move_wr;
      t_move_rd;
      t_fetch;
      report_and_stop;
   end
endmodule
